// ### rtc_alarm_time_control.sv
`timescale 1ns/1ps
module rtc_alarm_time_control
   import rtc_alarm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWriteData,
   output logic [15:0] regReadData,
   input wire logic [6:0] alarmSecond,
   input wire logic [6:0] alarmMinute,
   input wire logic [6:0] curSecond,
   input wire logic [6:0] curMinute,
   input wire logic [5:0] curHour,
   input wire logic [2:0] curWeekday,
   input wire logic [5:0] curDate,
   input wire logic [4:0] curMonth,
   input wire logic counterHaltedIn,
   output logic counterStopCmd,
   output logic alarmStopCmd,
   output logic alarmStoppedFlag,
   output logic bcdSel,
   output logic twelveHourSel,
   output logic alarmEvent
);
   alarm_match_if m ();

   logic [3:0] alarmWeekday;
   logic alarmMeridiem;
   logic [4:0] alarmHour;
   logic [4:0] alarmMonth;
   logic [5:0] alarmDate;
   logic prevMatch;
   logic [15:0] next_readData;
   logic wrHoursDay;
   logic wrDateMonth;
   logic wrControl;

   function automatic logic hitAddr(input logic [7:0] addr,
                                    input logic [7:0] target);
      hitAddr = addr == target;
   endfunction

   assign wrHoursDay = regWrite && hitAddr(regAddr, ADDR_ALARM_HOURS_DAY);
   assign wrDateMonth = regWrite && hitAddr(regAddr, ADDR_ALARM_DATE_MONTH);
   assign wrControl = regWrite && hitAddr(regAddr, ADDR_CLOCK_TIME_CONTROL);

   // ------------------------------------------------------------
   // Alarm field registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         alarmWeekday <= WEEKDAY_RESET;
         alarmMeridiem <= MERIDIEM_RESET;
         alarmHour <= HOUR_RESET;
      end else if (wrHoursDay) begin
         alarmWeekday <= regWriteData[WEEKDAY_LSB +: 4];
         alarmMeridiem <= regWriteData[MERIDIEM_BIT];
         alarmHour <= regWriteData[HOUR_LSB +: 5];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         alarmMonth <= MONTH_RESET;
         alarmDate <= DATE_RESET;
      end else if (wrDateMonth) begin
         alarmMonth <= regWriteData[MONTH_LSB +: 5];
         alarmDate <= regWriteData[DATE_LSB +: 6];
      end
   end

   // ------------------------------------------------------------
   // Time control register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bcdSel <= BCD_RESET;
         twelveHourSel <= TWELVE_HOUR_RESET;
         counterStopCmd <= COUNTER_STOP_RESET;
         alarmStopCmd <= ALARM_STOP_RESET;
      end else if (wrControl) begin
         bcdSel <= regWriteData[BCD_BIT];
         twelveHourSel <= regWriteData[TWELVE_HOUR_BIT];
         counterStopCmd <= regWriteData[COUNTER_STOP_BIT];
         alarmStopCmd <= regWriteData[ALARM_STOP_BIT];
      end
   end

   // Alarm circuit takes the stop instruction one cycle later
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         alarmStoppedFlag <= ALARM_STOPPED_RESET;
      end else begin
         alarmStoppedFlag <= alarmStopCmd;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      next_readData = 16'h0000;
      case (regAddr)
         ADDR_ALARM_HOURS_DAY: begin
            next_readData[WEEKDAY_LSB +: 4] = alarmWeekday;
            next_readData[MERIDIEM_BIT] = alarmMeridiem;
            next_readData[HOUR_LSB +: 5] = alarmHour;
         end
         ADDR_ALARM_DATE_MONTH: begin
            next_readData[MONTH_LSB +: 5] = alarmMonth;
            next_readData[DATE_LSB +: 6] = alarmDate;
         end
         ADDR_CLOCK_TIME_CONTROL: begin
            next_readData[BCD_BIT] = bcdSel;
            next_readData[TWELVE_HOUR_BIT] = twelveHourSel;
            next_readData[COUNTER_STOP_BIT] = counterStopCmd;
            next_readData[COUNTER_STOPPED_BIT] = counterHaltedIn;
            next_readData[ALARM_STOP_BIT] = alarmStopCmd;
            next_readData[ALARM_STOPPED_BIT] = alarmStoppedFlag;
         end
         default: begin
            next_readData = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regReadData <= 16'h0000;
      end else if (regRead) begin
         regReadData <= next_readData;
      end
   end

   // ------------------------------------------------------------
   // Alarm comparison and event
   // ------------------------------------------------------------
   assign m.alarmSecond = alarmSecond;
   assign m.alarmMinute = alarmMinute;
   assign m.alarmHour = alarmHour;
   assign m.alarmMeridiem = alarmMeridiem;
   assign m.alarmWeekday = alarmWeekday;
   assign m.alarmDate = alarmDate;
   assign m.alarmMonth = alarmMonth;
   assign m.curSecond = curSecond;
   assign m.curMinute = curMinute;
   assign m.curHour = curHour;
   assign m.curWeekday = curWeekday;
   assign m.curDate = curDate;
   assign m.curMonth = curMonth;
   assign m.twelveHour = twelveHourSel;

   alarm_compare u_compare (
      .clk(clk),
      .reset_n(reset_n),
      .port(m)
   );

   // One pulse per entry into a match, only while alarms run
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prevMatch <= 1'b0;
         alarmEvent <= 1'b0;
      end else begin
         prevMatch <= m.match;
         alarmEvent <= m.match && !prevMatch && !alarmStoppedFlag;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_ctrl_write;
      wrControl;
   endsequence
   sequence s_stop_settles;
      ##1 alarmStopCmd ##1 alarmStoppedFlag;
   endsequence

   a_alarm_stop_reset: assert property (
      $rose(reset_n) |-> alarmStopCmd && alarmStoppedFlag)
      else $error("alarms not stopped after reset");
   a_stop_settles: assert property (
      s_ctrl_write and regWriteData[ALARM_STOP_BIT] |-> s_stop_settles)
      else $error("alarm stop did not reach status");
   a_no_event_stopped: assert property (
      alarmEvent |-> !$past(alarmStoppedFlag))
      else $error("alarm event while alarms stopped");
   a_event_on_match: assert property (
      (m.match && !prevMatch && !alarmStoppedFlag) |=> alarmEvent)
      else $error("match did not raise alarm event");
   a_counter_stop: assert property (
      s_ctrl_write |=> counterStopCmd == $past(regWriteData[COUNTER_STOP_BIT]))
      else $error("counter stop instruction not applied");
   a_counter_status: assert property (
      (regRead && regAddr == ADDR_CLOCK_TIME_CONTROL)
      |=> regReadData[COUNTER_STOPPED_BIT] == $past(counterHaltedIn))
      else $error("counter status misreported");
   a_coding_select: assert property (
      s_ctrl_write |=> bcdSel == $past(regWriteData[BCD_BIT]))
      else $error("coding select not applied");
   a_hour_format: assert property (
      s_ctrl_write |=> twelveHourSel == $past(regWriteData[TWELVE_HOUR_BIT]))
      else $error("hour format select not applied");
   a_event_one_shot: assert property (
      alarmEvent |=> !alarmEvent)
      else $error("alarm event lasted more than one cycle");
   a_weekday_read: assert property (
      (regRead && regAddr == ADDR_ALARM_HOURS_DAY)
      |=> regReadData[WEEKDAY_LSB +: 4] == $past(alarmWeekday))
      else $error("weekday field misread");
   a_stopped_read: assert property (
      (regRead && regAddr == ADDR_CLOCK_TIME_CONTROL)
      |=> regReadData[ALARM_STOPPED_BIT] == $past(alarmStoppedFlag))
      else $error("alarm status misreported");
   a_date_write: assert property (
      wrDateMonth |=> alarmDate == $past(regWriteData[DATE_LSB +: 6]))
      else $error("date field not written");
endmodule

// ### rtc_alarm_pkg.sv
// Behaviour
// - Alarm weekday in bits 11:8, 1..7 with 1 Sunday; all ones is don't-care.
// - Alarm hour in bits 4:0, 0..23 or 1..12; all ones is don't-care.
// - Bit 5 is alarm PM flag, compared only in 12-hour mode.
// - Alarm month in bits 12:8, 1..12; all ones is don't-care.
// - Alarm date in bits 5:0, 1..31; all ones is don't-care.
// - Control bit 15 selects binary (0) or BCD (1) coding.
// - Bit 14 selects 12-hour mode; in 24-hour mode hour top bit is 0.
// - Writing control bit 11 to 1 halts the seconds counter, 0 runs it.
// - Control bit 10 reports the real seconds counter stopped state.
// - Control bit 9 stops alarms when 1, resumes when 0; resets to 1.
// - Alarm seconds and minutes 0..59; all ones is don't-care.
// - Control bit 8 reports real alarm circuit stopped state; resets to 1.
// - Current hour 0..23 or 1..12, bit 5 is PM flag in 12-hour mode.
package rtc_alarm_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_ALARM_HOURS_DAY = 8'h15;
   localparam logic [7:0] ADDR_ALARM_DATE_MONTH = 8'h16;
   localparam logic [7:0] ADDR_CLOCK_TIME_CONTROL = 8'h17;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int WEEKDAY_LSB = 8;
   localparam int MERIDIEM_BIT = 5;
   localparam int HOUR_LSB = 0;
   localparam int MONTH_LSB = 8;
   localparam int DATE_LSB = 0;
   localparam int BCD_BIT = 15;
   localparam int TWELVE_HOUR_BIT = 14;
   localparam int COUNTER_STOP_BIT = 11;
   localparam int COUNTER_STOPPED_BIT = 10;
   localparam int ALARM_STOP_BIT = 9;
   localparam int ALARM_STOPPED_BIT = 8;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [3:0] WEEKDAY_RESET = 4'h0;
   localparam logic MERIDIEM_RESET = 1'b0;
   localparam logic [4:0] HOUR_RESET = 5'h00;
   localparam logic [4:0] MONTH_RESET = 5'h00;
   localparam logic [5:0] DATE_RESET = 6'h00;
   localparam logic BCD_RESET = 1'b0;
   localparam logic TWELVE_HOUR_RESET = 1'b0;
   localparam logic COUNTER_STOP_RESET = 1'b0;
   localparam logic ALARM_STOP_RESET = 1'b1;
   localparam logic ALARM_STOPPED_RESET = 1'b1;
   // ------------------------------------------------------------
   // Don't-care codes
   // ------------------------------------------------------------
   localparam logic [6:0] DC_SECMIN = 7'h7f;
   localparam logic [6:0] DC_HOUR = 7'h1f;
   localparam logic [6:0] DC_WEEKDAY = 7'h0f;
   localparam logic [6:0] DC_MONTH = 7'h1f;
   localparam logic [6:0] DC_DATE = 7'h3f;
endpackage

// ### alarm_match_if.sv
`timescale 1ns/1ps
interface alarm_match_if;
   logic [6:0] alarmSecond;
   logic [6:0] alarmMinute;
   logic [4:0] alarmHour;
   logic alarmMeridiem;
   logic [3:0] alarmWeekday;
   logic [5:0] alarmDate;
   logic [4:0] alarmMonth;
   logic [6:0] curSecond;
   logic [6:0] curMinute;
   logic [5:0] curHour;
   logic [2:0] curWeekday;
   logic [5:0] curDate;
   logic [4:0] curMonth;
   logic twelveHour;
   logic match;
   modport cmp (
      input alarmSecond, alarmMinute, alarmHour, alarmMeridiem,
      input alarmWeekday, alarmDate, alarmMonth,
      input curSecond, curMinute, curHour, curWeekday, curDate, curMonth,
      input twelveHour,
      output match
   );
   modport ctl (
      output alarmSecond, alarmMinute, alarmHour, alarmMeridiem,
      output alarmWeekday, alarmDate, alarmMonth,
      output curSecond, curMinute, curHour, curWeekday, curDate, curMonth,
      output twelveHour,
      input match
   );
endinterface

// ### alarm_compare.sv
`timescale 1ns/1ps
module alarm_compare
   import rtc_alarm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   alarm_match_if.cmp port
);
   // ------------------------------------------------------------
   // Field comparison
   // ------------------------------------------------------------
   function automatic logic fieldHit(input logic [6:0] alarm,
                                     input logic [6:0] cur,
                                     input logic [6:0] dc);
      fieldHit = (alarm == dc) || (alarm == cur);
   endfunction

   logic secHit;
   logic minHit;
   logic hourHit;
   logic dayHit;
   logic dateHit;
   logic monthHit;
   logic next_match;

   always_comb begin
      secHit = fieldHit(port.alarmSecond, port.curSecond, DC_SECMIN);
      minHit = fieldHit(port.alarmMinute, port.curMinute, DC_SECMIN);
      // PM bits only meet in 12-hour mode; raw codes compared as stored
      hourHit = ({2'b00, port.alarmHour} == DC_HOUR) ||
                (port.alarmHour == port.curHour[4:0] &&
                 (!port.twelveHour ||
                  port.alarmMeridiem == port.curHour[5]));
      dayHit = fieldHit({3'b000, port.alarmWeekday},
                        {4'b0000, port.curWeekday}, DC_WEEKDAY);
      dateHit = fieldHit({1'b0, port.alarmDate}, {1'b0, port.curDate},
                         DC_DATE);
      monthHit = fieldHit({2'b00, port.alarmMonth}, {2'b00, port.curMonth},
                          DC_MONTH);
      next_match = secHit && minHit && hourHit && dayHit && dateHit &&
                   monthHit;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         port.match <= 1'b0;
      end else begin
         port.match <= next_match;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_date_mismatch: assert property (
      (port.alarmDate != 6'h3f && port.alarmDate != port.curDate)
      |=> !port.match) else $error("date mismatch still matched");
   a_month_mismatch: assert property (
      (port.alarmMonth != 5'h1f && port.alarmMonth != port.curMonth)
      |=> !port.match) else $error("month mismatch still matched");
   a_weekday_mismatch: assert property (
      (port.alarmWeekday != 4'hf &&
       port.alarmWeekday != {1'b0, port.curWeekday})
      |=> !port.match) else $error("weekday mismatch still matched");
   a_hour_mismatch: assert property (
      (port.alarmHour != 5'h1f && port.alarmHour != port.curHour[4:0])
      |=> !port.match) else $error("hour mismatch still matched");
   a_meridiem_check: assert property (
      (port.twelveHour && port.alarmHour != 5'h1f &&
       port.alarmMeridiem != port.curHour[5])
      |=> !port.match) else $error("meridiem mismatch still matched");
   a_all_dontcare: assert property (
      (port.alarmSecond == 7'h7f && port.alarmMinute == 7'h7f &&
       port.alarmHour == 5'h1f && port.alarmWeekday == 4'hf &&
       port.alarmDate == 6'h3f && port.alarmMonth == 5'h1f)
      |=> port.match) else $error("all don't-care did not match");
   a_exact_match: assert property (
      (port.alarmSecond == port.curSecond &&
       port.alarmMinute == port.curMinute &&
       port.alarmHour == port.curHour[4:0] && !port.twelveHour &&
       port.alarmWeekday == {1'b0, port.curWeekday} &&
       port.alarmDate == port.curDate && port.alarmMonth == port.curMonth)
      |=> port.match) else $error("exact time did not match");
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
   import rtc_alarm_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWriteData = 16'h0000;
   logic [15:0] regReadData;
   logic [6:0] alarmSecond = 7'h00;
   logic [6:0] alarmMinute = 7'h00;
   logic [6:0] curSecond = 7'h00;
   logic [6:0] curMinute = 7'h00;
   logic [5:0] curHour = 6'h00;
   logic [2:0] curWeekday = 3'h0;
   logic [5:0] curDate = 6'h00;
   logic [4:0] curMonth = 5'h00;
   logic counterHaltedIn = 1'b0;
   logic counterStopCmd;
   logic alarmStopCmd;
   logic alarmStoppedFlag;
   logic bcdSel;
   logic twelveHourSel;
   logic alarmEvent;
   int failCount = 0;
   int nCompared = 0;
   int cycles = 0;

   rtc_alarm_time_control dut_u (.clk(clk), .reset_n(reset_n),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWriteData(regWriteData), .regReadData(regReadData),
      .alarmSecond(alarmSecond), .alarmMinute(alarmMinute),
      .curSecond(curSecond), .curMinute(curMinute), .curHour(curHour),
      .curWeekday(curWeekday), .curDate(curDate), .curMonth(curMonth),
      .counterHaltedIn(counterHaltedIn), .counterStopCmd(counterStopCmd),
      .alarmStopCmd(alarmStopCmd), .alarmStoppedFlag(alarmStoppedFlag),
      .bcdSel(bcdSel), .twelveHourSel(twelveHourSel),
      .alarmEvent(alarmEvent));

   always #12.5 clk = ~clk;

   // ------------------------------------------------------------
   // Verdict and hang guard
   // ------------------------------------------------------------
   task automatic endSim();
      if (failCount == 0 && nCompared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         failCount++;
         $display("BAD %0t run did not finish", $time);
         endSim();
      end
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      nCompared++;
      if (got !== exp) begin
         failCount++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWriteData = d;
      @(posedge clk);
      @(negedge clk);
      regWrite = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                     input string what);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      @(posedge clk);
      @(negedge clk);
      regRead = 1'b0;
      chk(regReadData, exp, what);
   endtask

   // Fields are loaded with alarms stopped, time is moved off the alarm,
   // alarms are released, then the time steps onto the alarm.
   task automatic trial(input logic [15:0] ctl, hd, dm,
                        input logic [6:0] aS, aM, cS, cM,
                        input logic [5:0] cH, input logic [2:0] cW,
                        input logic [5:0] cD, input logic [4:0] cMo,
                        input logic [15:0] exp);
      int pulses;
      pulses = 0;
      wr(ADDR_CLOCK_TIME_CONTROL, ctl | 16'h0200);
      wr(ADDR_ALARM_HOURS_DAY, hd);
      wr(ADDR_ALARM_DATE_MONTH, dm);
      @(negedge clk);
      alarmSecond = aS;
      alarmMinute = aM;
      curSecond = cS ^ 7'h01;
      curMinute = cM ^ 7'h01;
      curHour = cH ^ 6'h01;
      curWeekday = cW ^ 3'h1;
      curDate = cD ^ 6'h01;
      curMonth = cMo ^ 5'h01;
      wr(ADDR_CLOCK_TIME_CONTROL, ctl);
      repeat (3) @(negedge clk);
      curSecond = cS;
      curMinute = cM;
      curHour = cH;
      curWeekday = cW;
      curDate = cD;
      curMonth = cMo;
      repeat (6) begin
         @(negedge clk);
         if (alarmEvent === 1'b1) pulses++;
      end
      chk(16'(pulses), exp, "alarm pulses");
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      chk(16'({alarmStopCmd, alarmStoppedFlag}), 16'h0003,
          "stop reset");
      chk(16'({bcdSel, twelveHourSel, counterStopCmd}), 16'h0000,
          "ctl out");
      rd(8'h15, 16'h0000, "hours/day reset");
      rd(8'h16, 16'h0000, "date/month reset");
      rd(8'h17, 16'h0300, "control reset");
      wr(8'h15, 16'hffff);
      rd(8'h15, 16'h0f3f, "hours/day fields");
      wr(8'h16, 16'hffff);
      rd(8'h16, 16'h1f3f, "date/month fields");
      counterHaltedIn = 1'b1;
      wr(8'h17, 16'hffff);
      chk(16'({bcdSel, twelveHourSel, counterStopCmd}), 16'h0007,
          "ctl set");
      rd(8'h17, 16'hcf00, "control all set");
      counterHaltedIn = 1'b0;
      wr(8'h17, 16'h0500);
      chk(16'({alarmStopCmd, alarmStoppedFlag}), 16'h0001,
          "stop lag");
      @(negedge clk);
      chk(16'(alarmStoppedFlag), 16'h0000, "stopped flag");
      rd(8'h17, 16'h0000, "status read-only");
      wr(8'h14, 16'hffff);
      rd(8'h14, 16'h0000, "unmapped read");
      rd(8'h15, 16'h0f3f, "unmapped write");
      trial(16'h0000, 16'h030e, 16'h0514, 7'd30, 7'd45, 7'd30, 7'd45,
            6'd14, 3'd3, 6'd20, 5'd5, 16'h0001);
      trial(16'h0000, 16'h0f3f, 16'h1f3f, 7'd10, 7'h7f, 7'd10, 7'd3,
            6'd9, 3'd6, 6'd2, 5'd11,
            16'h0001);
      trial(16'h0000, 16'h030e, 16'h0514, 7'd30, 7'd45, 7'd30, 7'd45,
            6'd14, 3'd3, 6'd21, 5'd5, 16'h0000);
      trial(16'h0000, 16'h030e, 16'h0514, 7'd30, 7'd45, 7'd30, 7'd44,
            6'd14, 3'd4, 6'd20, 5'd5, 16'h0000);
      trial(16'h4000, 16'h0123, 16'h0514, 7'd30, 7'd45, 7'd30, 7'd45,
            6'h23, 3'd1, 6'd20, 5'd5, 16'h0001);
      trial(16'h4000, 16'h0123, 16'h0514, 7'd30, 7'd45, 7'd30, 7'd45,
            6'h03, 3'd1, 6'd20, 5'd5, 16'h0000);
      trial(16'h0000, 16'h0103, 16'h0514, 7'd30, 7'd45, 7'd30, 7'd45,
            6'h03, 3'd1, 6'd20, 5'd5, 16'h0001);
      trial(16'h8000, 16'h0312, 16'h1231, 7'h59, 7'h45, 7'h59, 7'h45,
            6'h12, 3'd3, 6'h31, 5'h12, 16'h0001);
      trial(16'h8000, 16'h0312, 16'h1231, 7'h59, 7'h45, 7'h59, 7'h45,
            6'd12, 3'd3, 6'h31, 5'h12, 16'h0000);
      trial(16'h0200, 16'h030e, 16'h0514, 7'd30, 7'd45, 7'd30, 7'd45,
            6'd14, 3'd3, 6'd20, 5'd5, 16'h0000);
      // All fields don't-care: match never drops, so no new event
      trial(16'h0000, 16'h0f3f, 16'h1f3f, 7'h7f, 7'h7f, 7'd10, 7'd3,
            6'd9, 3'd6, 6'd2, 5'd11, 16'h0000);
      endSim();
   end
endmodule
